//--- lcc_top.sv
/*
 Register bank and protection outputs for two laser channels.
 Assumes a serial front end delivering one-cycle read and write strobes
 with an 8-bit address, and comparators synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_top
    import lcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port from the serial front end
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Analog side inputs
    input wire logic overcurrent_cmp_ch1,
    input wire logic overcurrent_cmp_ch2,
    input wire logic [9:0] reference_code_ch1,
    input wire logic [9:0] reference_code_ch2,
    // Error pin
    output logic error_out_n,
    // Channel 1 controls
    output logic laser_enable_ch1,
    output logic protect_on_ch1,
    output logic constant_current_mode_ch1,
    output logic internal_resistor_off_ch1,
    output logic adc_at_pin_ch1,
    output logic [9:0] dac_code_ch1,
    output logic [29:0] ilim_x10ua_ch1,
    output logic [12:0] full_scale_x01ma_ch1,
    // Channel 2 controls
    output logic laser_enable_ch2,
    output logic protect_on_ch2,
    output logic constant_current_mode_ch2,
    output logic internal_resistor_off_ch2,
    output logic adc_at_pin_ch2,
    output logic [9:0] dac_code_ch2,
    output logic [29:0] ilim_x10ua_ch2,
    output logic [12:0] full_scale_x01ma_ch2
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0] mode_q, next_mode;
    logic [1:0] res_off_q, next_res_off;
    logic [7:0] thr_q [2];
    logic [7:0] next_thr [2];
    logic [1:0] low_q, next_low;
    logic [1:0] mps_q, next_mps;
    logic [1:0] force_q, next_force;
    logic [1:0] fs_q [2];
    logic [1:0] next_fs [2];
    logic [7:0] next_rdata;
    logic status_read;
    logic [1:0] ovc;
    logic [1:0] en;
    logic [1:0] prot;
    logic [29:0] ilim [2];
    logic [12:0] fsv [2];

    lcc_chan_if chif[2] ();

    // Write strobe aimed at one offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        return reg_wr && reg_addr == ofs;
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Only documented bits are stored; the rest read back as zero
    always_comb begin
        next_mode = mode_q;
        next_res_off = res_off_q;
        next_thr = thr_q;
        next_low = low_q;
        next_mps = mps_q;
        next_force = force_q;
        next_fs = fs_q;
        if (wr_hit(OFS_MODE_CH1)) begin
            next_mode[0] = reg_wdata[BIT_MODE];
            next_res_off[0] = reg_wdata[BIT_RES_OFF];
        end else if (wr_hit(OFS_THR_CH1)) begin
            next_thr[0] = reg_wdata;
        end else if (wr_hit(OFS_MODE_CH2)) begin
            next_mode[1] = reg_wdata[BIT_MODE];
            next_res_off[1] = reg_wdata[BIT_RES_OFF];
        end else if (wr_hit(OFS_THR_CH2)) begin
            next_thr[1] = reg_wdata;
        end else if (wr_hit(OFS_RANGE)) begin
            next_low = {reg_wdata[BIT_LOW_CH2], reg_wdata[BIT_LOW_CH1]};
            next_mps = {reg_wdata[BIT_MPS_CH2], reg_wdata[BIT_MPS_CH1]};
        end else if (wr_hit(OFS_FORCE)) begin
            next_force = {reg_wdata[BIT_FORCE_CH2], reg_wdata[BIT_FORCE_CH1]};
        end else if (wr_hit(OFS_FSCALE)) begin
            next_fs[0] = reg_wdata[BIT_FS_CH1 +: 2];
            next_fs[1] = reg_wdata[BIT_FS_CH2 +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q <= 2'h0;
            res_off_q <= 2'h0;
            thr_q[0] <= RST_THR;
            thr_q[1] <= RST_THR;
            low_q <= 2'h0;
            mps_q <= 2'h0;
            force_q <= 2'h0;
            fs_q[0] <= RST_FS;
            fs_q[1] <= RST_FS;
        end else begin
            mode_q <= next_mode;
            res_off_q <= next_res_off;
            thr_q <= next_thr;
            low_q <= next_low;
            mps_q <= next_mps;
            force_q <= next_force;
            fs_q <= next_fs;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Reading status acknowledges the overcurrent flags at the same edge
    assign status_read = reg_rd && reg_addr == OFS_STATUS;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == OFS_STATUS) begin
            next_rdata[BIT_OVC_CH1] = ovc[0];
            next_rdata[BIT_OVC_CH2] = ovc[1];
        end else if (reg_addr == OFS_MODE_CH1) begin
            next_rdata[BIT_MODE] = mode_q[0];
            next_rdata[BIT_RES_OFF] = res_off_q[0];
        end else if (reg_addr == OFS_THR_CH1) begin
            next_rdata = thr_q[0];
        end else if (reg_addr == OFS_MODE_CH2) begin
            next_rdata[BIT_MODE] = mode_q[1];
            next_rdata[BIT_RES_OFF] = res_off_q[1];
        end else if (reg_addr == OFS_THR_CH2) begin
            next_rdata = thr_q[1];
        end else if (reg_addr == OFS_RANGE) begin
            next_rdata[BIT_LOW_CH1] = low_q[0];
            next_rdata[BIT_MPS_CH1] = mps_q[0];
            next_rdata[BIT_LOW_CH2] = low_q[1];
            next_rdata[BIT_MPS_CH2] = mps_q[1];
        end else if (reg_addr == OFS_FORCE) begin
            next_rdata[BIT_FORCE_CH1] = force_q[0];
            next_rdata[BIT_FORCE_CH2] = force_q[1];
        end else if (reg_addr == OFS_FSCALE) begin
            next_rdata[BIT_FS_CH1 +: 2] = fs_q[0];
            next_rdata[BIT_FS_CH2 +: 2] = fs_q[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // ------------------------------------------------------------
    // Channel instances
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign chif[g].mode_cc = mode_q[g];
        assign chif[g].low_range = low_q[g];
        assign chif[g].thr = thr_q[g];
        assign chif[g].fs_code = fs_q[g];
        assign chif[g].force_ovc = force_q[g];
        assign chif[g].cmp = (g == 0) ? overcurrent_cmp_ch1 : overcurrent_cmp_ch2;
        assign chif[g].ack = status_read;
        assign ovc[g] = chif[g].ovc;
        assign en[g] = chif[g].enable;
        assign prot[g] = chif[g].protect_on;
        assign ilim[g] = chif[g].ilim_x10ua;
        assign fsv[g] = chif[g].fs_x01ma;
        lcc_channel u_chan (
            .clk(clk),
            .resetn(resetn),
            .ch(chif[g])
        );
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // One cycle of latency keeps every pin glitch free
    always_ff @(posedge clk) begin
        if (!resetn) begin
            error_out_n <= 1'b1;
            laser_enable_ch1 <= 1'b0;
            laser_enable_ch2 <= 1'b0;
            protect_on_ch1 <= 1'b1;
            protect_on_ch2 <= 1'b1;
            constant_current_mode_ch1 <= 1'b0;
            constant_current_mode_ch2 <= 1'b0;
            internal_resistor_off_ch1 <= 1'b0;
            internal_resistor_off_ch2 <= 1'b0;
            adc_at_pin_ch1 <= 1'b0;
            adc_at_pin_ch2 <= 1'b0;
            dac_code_ch1 <= 10'h000;
            dac_code_ch2 <= 10'h000;
            ilim_x10ua_ch1 <= 30'h0;
            ilim_x10ua_ch2 <= 30'h0;
            full_scale_x01ma_ch1 <= 13'h0;
            full_scale_x01ma_ch2 <= 13'h0;
        end else begin
            // No mask exists for overcurrent, so any set flag pulls the pin
            error_out_n <= !(ovc[0] || ovc[1]);
            laser_enable_ch1 <= en[0];
            laser_enable_ch2 <= en[1];
            protect_on_ch1 <= prot[0];
            protect_on_ch2 <= prot[1];
            constant_current_mode_ch1 <= mode_q[0];
            constant_current_mode_ch2 <= mode_q[1];
            internal_resistor_off_ch1 <= res_off_q[0];
            internal_resistor_off_ch2 <= res_off_q[1];
            // Routing follows software's choice
            adc_at_pin_ch1 <= mps_q[0];
            adc_at_pin_ch2 <= mps_q[1];
            dac_code_ch1 <= reference_code_ch1;
            dac_code_ch2 <= reference_code_ch2;
            ilim_x10ua_ch1 <= ilim[0];
            ilim_x10ua_ch2 <= ilim[1];
            full_scale_x01ma_ch1 <= fsv[0];
            full_scale_x01ma_ch2 <= fsv[1];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_force_write;
        reg_wr && reg_addr == OFS_FORCE && reg_wdata[BIT_FORCE_CH1];
    endsequence
    sequence s_pin_low;
        ##2 !laser_enable_ch1 ##0 !error_out_n;
    endsequence

    AST_FORCE_PIN: assert property (@(posedge clk) disable iff (!resetn)
        s_force_write |-> ##1 s_pin_low) else $error("force did not reach pins");
    AST_THR_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == OFS_THR_CH2 |=> thr_q[1] == $past(reg_wdata))
        else $error("threshold write lost");
    // Flag must drop right after the acknowledge; a new event may set it later
    AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
        status_read && !force_q[0] && !overcurrent_cmp_ch1 |=> !ovc[0]
        ##1 (laser_enable_ch1 || force_q[0] || ovc[0]))
        else $error("acknowledge did not re-enable");
    AST_FS_TABLE: assert property (@(posedge clk) disable iff (!resetn)
        low_q[0] && fs_q[0] == 2'h3 |=> full_scale_x01ma_ch1 == FS_LO_11)
        else $error("full scale table wrong");
endmodule
`default_nettype wire

//--- lcc_pkg.sv
/*
 Constants for the two-channel laser current configuration block: register
 offsets, field positions, reset values and scaling tables.
 Assumes a serial front end that turns host frames into register strobes.
*/
`default_nettype none
package lcc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MODE_CH1 = 8'h10;
    localparam logic [7:0] OFS_THR_CH1 = 8'h11;
    localparam logic [7:0] OFS_MODE_CH2 = 8'h15;
    localparam logic [7:0] OFS_THR_CH2 = 8'h16;
    localparam logic [7:0] OFS_RANGE = 8'h1A;
    localparam logic [7:0] OFS_FORCE = 8'h1D;
    localparam logic [7:0] OFS_FSCALE = 8'h1E;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_MODE = 0;
    localparam int BIT_RES_OFF = 2;
    localparam int BIT_LOW_CH1 = 0;
    localparam int BIT_MPS_CH1 = 2;
    localparam int BIT_LOW_CH2 = 4;
    localparam int BIT_MPS_CH2 = 6;
    localparam int BIT_FORCE_CH1 = 5;
    localparam int BIT_FORCE_CH2 = 6;
    localparam int BIT_FS_CH1 = 0;
    localparam int BIT_FS_CH2 = 4;
    localparam int BIT_OVC_CH2 = 4;
    localparam int BIT_OVC_CH1 = 5;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_THR = 8'hFF;
    localparam logic [1:0] RST_FS = 2'h0;
    // ------------------------------------------------------------
    // Scaling: step in uA, factor k times ten, full scale in 0.1 mA
    // ------------------------------------------------------------
    localparam logic [11:0] STEP_LOW_UA = 12'h177;  // 375 uA
    localparam logic [11:0] STEP_HIGH_UA = 12'hBB8; // 3000 uA
    localparam logic [9:0] K10_00 = 10'h00A;  // 1
    localparam logic [9:0] K10_01 = 10'h04B;  // 7.5
    localparam logic [9:0] K10_10 = 10'h12C;  // 30
    localparam logic [9:0] K10_11 = 10'h341;  // 83.3
    localparam logic [12:0] FS_HI_00 = 13'h1D4C; // 750 mA
    localparam logic [12:0] FS_HI_01 = 13'h03E8; // 100 mA
    localparam logic [12:0] FS_HI_10 = 13'h00FA; // 25 mA
    localparam logic [12:0] FS_HI_11 = 13'h005A; // 9 mA
    localparam logic [12:0] FS_LO_00 = 13'h0384; // 90 mA
    localparam logic [12:0] FS_LO_01 = 13'h0078; // 12 mA
    localparam logic [12:0] FS_LO_10 = 13'h001E; // 3 mA
    localparam logic [12:0] FS_LO_11 = 13'h000B; // 1.1 mA
endpackage
`default_nettype wire

//--- lcc_chan_if.sv
/*
 Carrier between the register bank and one channel's protection logic.
 Assumes one instance per channel inside the top module.
*/
`timescale 1ns/100ps
`default_nettype none
interface lcc_chan_if;
    logic mode_cc;
    logic low_range;
    logic [7:0] thr;
    logic [1:0] fs_code;
    logic force_ovc;
    logic cmp;
    logic ack;
    logic ovc;
    logic enable;
    logic protect_on;
    logic [29:0] ilim_x10ua;
    logic [12:0] fs_x01ma;
    modport cfg (output mode_cc, low_range, thr, fs_code, force_ovc, cmp, ack,
                 input ovc, enable, protect_on, ilim_x10ua, fs_x01ma);
    modport chan (input mode_cc, low_range, thr, fs_code, force_ovc, cmp, ack,
                  output ovc, enable, protect_on, ilim_x10ua, fs_x01ma);
endinterface
`default_nettype wire

//--- lcc_channel.sv
/*
 One laser channel: threshold scaling, full-scale lookup and the sticky
 overcurrent error flag. Assumes cmp is the analog comparator result,
 already synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_channel
    import lcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Channel carrier
    lcc_chan_if.chan ch
);
    logic ovc_q;
    logic next_ovc;
    logic set_ovc;
    logic [11:0] step_ua;
    logic [9:0] k10;

    // Scaling tables, constants only
    always_comb begin
        step_ua = ch.low_range ? STEP_LOW_UA : STEP_HIGH_UA;
        case (ch.fs_code)
            2'h0: k10 = K10_00;
            2'h1: k10 = K10_01;
            2'h2: k10 = K10_10;
            default: k10 = K10_11;
        endcase
        case ({ch.low_range, ch.fs_code})
            3'h0: ch.fs_x01ma = FS_HI_00;
            3'h1: ch.fs_x01ma = FS_HI_01;
            3'h2: ch.fs_x01ma = FS_HI_10;
            3'h3: ch.fs_x01ma = FS_HI_11;
            3'h4: ch.fs_x01ma = FS_LO_00;
            3'h5: ch.fs_x01ma = FS_LO_01;
            3'h6: ch.fs_x01ma = FS_LO_10;
            default: ch.fs_x01ma = FS_LO_11;
        endcase
    end

    // Threshold value; code zero in constant-power mode gives the minimum
    assign ch.ilim_x10ua = 30'(step_ua * ch.thr * k10);
    // Zero code in constant-current mode disconnects the comparator
    assign ch.protect_on = !(ch.mode_cc && ch.thr == 8'h00);

    // Set wins over the acknowledge so no event is lost
    always_comb begin
        set_ovc = (ch.cmp && ch.protect_on) || ch.force_ovc;
        next_ovc = set_ovc || (ovc_q && !ch.ack);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ovc_q <= 1'b0;
        end else begin
            ovc_q <= next_ovc;
        end
    end

    assign ch.ovc = ovc_q;
    // Channel stays off until the flag is acknowledged and force is gone
    assign ch.enable = !ovc_q && !ch.force_ovc;

    AST_FORCE_SETS: assert property (@(posedge clk) disable iff (!resetn)
        ch.force_ovc |=> ch.ovc) else $error("force did not set error");
    AST_FORCE_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
        ch.force_ovc ##1 ch.force_ovc |-> ch.ovc && !ch.enable)
        else $error("forced error dropped");
    AST_DISCONNECT: assert property (@(posedge clk) disable iff (!resetn)
        ch.mode_cc && ch.thr == 8'h00 && !ch.force_ovc && ch.ack |=> !ch.ovc)
        else $error("protection not disconnected");
    AST_ILIM_MIN: assert property (@(posedge clk) disable iff (!resetn)
        !ch.mode_cc && ch.thr == 8'h00 |-> ch.protect_on && ch.ilim_x10ua == 30'h0)
        else $error("zero code not minimum threshold");
endmodule
`default_nettype wire

//--- lcc_host_model.sv
/*
 Host controller model: writes and reads the register port with one-cycle
 strobes and keeps the software duties of the measurement routing.
 Assumes strobes are taken on the rising edge of clk and are driven on the
 falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Data goes to its inverse after use so a stale value is never mistaken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // Answer is taken one cycle after the strobe; no answer reads as unknown
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask

    // Constant-current setup of both channels; the measure point follows the
    // resistor choice so the converter never looks at a dead node
    task automatic set_meas(input logic ext);
        wr(8'h10, {5'h00, ext, 2'h1});
        wr(8'h15, {5'h00, ext, 2'h1});
        wr(8'h1A, {1'b0, ext, 3'h0, ext, 2'h0});
    endtask
endmodule
`default_nettype wire

//--- laser_channel_current_config_tb.sv
/*
 Self-checking bench for the two-channel laser current configuration block.
 Assumes the host model drives the register port and the bench drives the
 comparator and reference inputs on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module laser_channel_current_config_tb;
    import lcc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_wr, reg_rd, reg_rvalid, error_out_n;
    logic overcurrent_cmp_ch1 = 1'b0, overcurrent_cmp_ch2 = 1'b0;
    logic [9:0] reference_code_ch1 = 10'h000, reference_code_ch2 = 10'h000;
    logic laser_enable_ch1, protect_on_ch1, constant_current_mode_ch1;
    logic internal_resistor_off_ch1, adc_at_pin_ch1;
    logic laser_enable_ch2, protect_on_ch2, constant_current_mode_ch2;
    logic internal_resistor_off_ch2, adc_at_pin_ch2;
    logic [9:0] dac_code_ch1, dac_code_ch2;
    logic [29:0] ilim_x10ua_ch1, ilim_x10ua_ch2;
    logic [12:0] full_scale_x01ma_ch1, full_scale_x01ma_ch2;
    int mismatches = 0;
    int tests_run = 0;

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;

    lcc_top DUT (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .overcurrent_cmp_ch1, .overcurrent_cmp_ch2, .reference_code_ch1,
        .reference_code_ch2, .error_out_n, .laser_enable_ch1, .protect_on_ch1,
        .constant_current_mode_ch1, .internal_resistor_off_ch1, .adc_at_pin_ch1,
        .dac_code_ch1, .ilim_x10ua_ch1, .full_scale_x01ma_ch1, .laser_enable_ch2,
        .protect_on_ch2, .constant_current_mode_ch2, .internal_resistor_off_ch2,
        .adc_at_pin_ch2, .dac_code_ch2, .ilim_x10ua_ch2, .full_scale_x01ma_ch2);

    lcc_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Outputs sit up to two register stages behind the write edge
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] adr[7] = '{8'h11, 8'h16, 8'h10, 8'h15, 8'h1A, 8'h1D, 8'h1E};
        logic [7:0] exv[7] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            host.rd(adr[i], rdv);
            chk(rdv, exv[i]);
        end
        chk(full_scale_x01ma_ch1, 13'h1D4C);
        chk(ilim_x10ua_ch2, 32'h0074BAD0);
    endtask

    // Every range bit and full-scale code, with a mid threshold on channel 1
    task automatic t_scale();
        logic [12:0] fs[8] = '{13'h1D4C, 13'h3E8, 13'hFA, 13'h5A,
            13'h384, 13'h78, 13'h1E, 13'hB};
        logic [9:0] k[4] = '{K10_00, K10_01, K10_10, K10_11};
        logic [31:0] st;
        host.wr(8'h11, 8'h80);
        for (int lo = 0; lo < 2; lo++) begin
            for (int c = 0; c < 4; c++) begin
                host.wr(8'h1A, {3'h0, lo[0], 3'h0, lo[0]});
                host.wr(8'h1E, {2'h0, c[1:0], 2'h0, c[1:0]});
                settle();
                st = lo ? 32'(STEP_LOW_UA) : 32'(STEP_HIGH_UA);
                chk(full_scale_x01ma_ch1, fs[lo * 4 + c]);
                chk(full_scale_x01ma_ch2, fs[lo * 4 + c]);
                chk(ilim_x10ua_ch1, st * 32'h80 * 32'(k[c]));
                chk(ilim_x10ua_ch2, st * 32'hFF * 32'(k[c]));
            end
        end
        host.wr(8'h1A, 8'h00);
        host.wr(8'h1E, 8'h00);
    endtask

    // Zero threshold: minimum in power mode, protection off in current mode
    task automatic t_zero();
        host.wr(8'h11, 8'h00);
        settle();
        chk(ilim_x10ua_ch1, 32'h0);
        chk(protect_on_ch1, 1'b1);
        overcurrent_cmp_ch1 = 1'b1;
        settle();
        chk({laser_enable_ch1, laser_enable_ch2, error_out_n}, 3'b010);
        overcurrent_cmp_ch1 = 1'b0;
        host.rd(8'h00, rdv);
        chk(rdv, 8'h20);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h00);
        host.wr(8'h10, 8'h01);
        settle();
        chk({laser_enable_ch1, error_out_n, protect_on_ch1}, 3'b110);
        overcurrent_cmp_ch1 = 1'b1;
        settle();
        chk({laser_enable_ch1, error_out_n}, 2'b11);
        overcurrent_cmp_ch1 = 1'b0;
        host.rd(8'h00, rdv);
        chk(rdv, 8'h00);
        host.wr(8'h10, 8'h00);
        host.wr(8'h11, 8'hFF);
    endtask

    // Forced errors hold while forced and clear only after a status read
    task automatic t_force();
        host.wr(8'h1D, 8'h20);
        settle();
        chk({laser_enable_ch1, laser_enable_ch2, error_out_n}, 3'b010);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h20);
        settle();
        chk({laser_enable_ch1, error_out_n}, 2'b00);
        host.wr(8'h1D, 8'h40);
        settle();
        host.rd(8'h1D, rdv);
        chk(rdv, 8'h40);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h30);
        chk(laser_enable_ch2, 1'b0);
        host.wr(8'h1D, 8'h00);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h10);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h00);
        settle();
        chk({laser_enable_ch1, laser_enable_ch2, error_out_n}, 3'b111);
    endtask

    // Routing and reference codes for both resistor choices
    task automatic t_meas();
        reference_code_ch1 = 10'h3FF;
        reference_code_ch2 = 10'h155;
        for (int e = 1; e >= 0; e--) begin
            host.set_meas(e[0]);
            settle();
            chk({constant_current_mode_ch1, constant_current_mode_ch2}, 2'b11);
            chk({internal_resistor_off_ch1, adc_at_pin_ch1}, {2{e[0]}});
            chk({internal_resistor_off_ch2, adc_at_pin_ch2}, {2{e[0]}});
            chk({dac_code_ch1, dac_code_ch2}, 20'hFFD55);
        end
        host.wr(8'h10, 8'h00);
        host.wr(8'h15, 8'h00);
    endtask

    // Channel 2 threshold register and its disconnect in current mode
    task automatic t_chan2();
        host.wr(8'h16, 8'h00);
        host.rd(8'h16, rdv);
        chk(rdv, 8'h00);
        host.wr(8'h15, 8'h01);
        overcurrent_cmp_ch2 = 1'b1;
        settle();
        chk({protect_on_ch2, laser_enable_ch2, error_out_n}, 3'b011);
        host.wr(8'h15, 8'h00);
        settle();
        chk({protect_on_ch2, laser_enable_ch2, error_out_n}, 3'b100);
        overcurrent_cmp_ch2 = 1'b0;
        host.rd(8'h00, rdv);
        chk(rdv, 8'h10);
        host.wr(8'h16, 8'hFF);
    endtask

    // Read-only status and an unmapped offset ignore writes
    task automatic t_refuse();
        host.wr(8'h00, 8'hFF);
        host.wr(8'h05, 8'hAA);
        host.rd(8'h05, rdv);
        chk(rdv, 8'h00);
        host.rd(8'h00, rdv);
        chk(rdv, 8'h00);
        chk(error_out_n, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_scale();
        t_zero();
        t_force();
        t_meas();
        t_chan2();
        t_refuse();
        end_sim();
    end

    // The run needs well under two thousand cycles; this allows forty thousand
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
